// file: tb/bdms_monitor.sv
`default_nettype none
module bdms_monitor (
  input wire clk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire [7:0] mem_addr_i,
  input wire mem_heart_o,
  input wire [1:0] band_o,
  input wire [3:0] high_digit_o,
  input wire [3:0] low_digit_o,
  input wire skip_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire [3:0] tens = mem_addr_i[7:4];
  wire [3:0] ones = mem_addr_i[3:0];
  wire [3:0] arg = wb_dat_i[7:4];
  wire [3:0] acc = wb_dat_i[15:12];
  // Accepted command word in the ack cycle
  sequence s_cmd(op);
    wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1:0] == 2'h3 && wb_dat_i[3:0] == op;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_heart_hit: assert property (!$past(reset_i) |->
    mem_heart_o == ($past(tens) inside {[4'h4:4'h9]} && $past(ones) <= 4'h9))
    else $error("heart flag wrong");
  a_digit_ok: assert property (high_digit_o <= 4'h9 && low_digit_o <= 4'h9)
    else $error("pointer not decimal");
  a_home_band: assert property (s_cmd(4'h1) ##0 (arg <= 4'h3 && !wb_dat_i[8]) |=>
    band_o == $past(arg[1:0]))
    else $error("home band wrong");
  a_step_band: assert property (s_cmd(4'h2) ##0 arg <= 4'h3 |=>
    band_o == $past(band_o) + 2'h1 && skip_o == (band_o == $past(arg[1:0]) + 2'h1))
    else $error("step band wrong");
  a_acc_high: assert property (s_cmd(4'h3) ##0 acc <= 4'h9 |=>
    high_digit_o == ($past(high_digit_o) + $past(acc)) % 5'h0a)
    else $error("high add wrong");
  a_acc_band: assert property (s_cmd(4'h6) ##0 acc <= 4'h9 |=>
    band_o == ($past(band_o) + $past(acc)) % 5'h04)
    else $error("band add wrong");
endmodule
bind bdms_top bdms_monitor u_mon (.*);
`default_nettype wire

// file: tb/bdms_seq_model.sv
`default_nettype none
module bdms_seq_model (
  input wire logic clk_i,
  output logic [7:0] mem_addr_o,
  output logic mem_we_o,
  output logic [48:0] mem_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mem_addr_o = 8'h40;
    mem_we_o = 1'b0;
    mem_wdata_o = 49'h0;
  end
  // One store reference; released data lines show the inverse
  task automatic put(input logic [7:0] adr, input logic we, input logic [48:0] dat);
    @(posedge clk_i);
    mem_addr_o <= adr;
    mem_we_o <= we;
    mem_wdata_o <= dat;
    @(posedge clk_i);
    mem_we_o <= 1'b0;
    mem_wdata_o <= ~dat;
  endtask
endmodule
`default_nettype wire

// file: tb/bdms_tb_top.sv
`default_nettype none
module bdms_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, manual_digit_i = 4'h2;
  logic [31:0] wb_dat_i = 32'h0, rd;
  logic [7:0] mem_addr_i;
  logic mem_we_i;
  logic [48:0] mem_wdata_i;
  wire [31:0] wb_dat_o;
  wire [48:0] mem_rdata_o;
  wire [1:0] band_o;
  wire [3:0] high_digit_o, low_digit_o;
  wire wb_ack_o, mem_heart_o, mem_addr_err_o, skip_o, err_o;
  int n_errors = 0, total_checks = 0, cycles = 0;
  // Command word, then expected status; pointers are homed before adding
  logic [47:0] rows [12] = '{48'h0031_00040003, 48'h0032_00050000, 48'h0002_00050001,
    48'h0077_00050071, 48'h5003_00050021, 48'h0098_00050921, 48'h3004_00050221,
    48'h9005_00050111, 48'h3006_00050110, 48'h0009_00070110, 48'h0041_00070110,
    48'h0101_00070112};
  bdms_top dut (.*);
  bdms_seq_model seq (.clk_i(clk_i), .mem_addr_o(mem_addr_i), .mem_we_o(mem_we_i), .mem_wdata_o(mem_wdata_i));
  initial forever #5 clk_i = ~clk_i;
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [48:0] seen, input logic [48:0] exp);
    total_checks++;
    if (seen !== exp)
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    if (seen !== exp)
      n_errors++;
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_store(input logic [7:0] adr, input logic [48:0] exp);
    seq.put(adr, 1'b0, 49'h0);
    @(posedge clk_i);
    check("store word", mem_rdata_o, exp);
    check("heart flag", mem_heart_o, adr[7:4] >= 4'h4 && adr[7:4] <= 4'h9 && adr[3:0] <= 4'h9);
    check("address error", mem_addr_err_o, adr[7:4] > 4'h9 || adr[3:0] > 4'h9);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    wb(1'b0, 4'h4, 32'h0);
    check("status after reset", rd, 32'h0004_0000);
    foreach (rows[i]) begin
      wb(1'b1, 4'h0, {16'h0, rows[i][47:32]});
      wb(1'b0, 4'h4, 32'h0);
      check("status", rd, rows[i][31:0]);
      check("band pins", band_o, rows[i][1:0]);
      check("high pins", high_digit_o, rows[i][7:4]);
      check("low pins", low_digit_o, rows[i][11:8]);
      check("skip pin", skip_o, rows[i][16]);
      check("error pin", err_o, rows[i][17]);
      $display("row %0d done", i);
    end
    wb(1'b1, 4'h4, 32'h0002_0000);
    wb(1'b0, 4'h4, 32'h0);
    check("status after clear", rd, 32'h0005_0112);
    wb(1'b0, 4'h8, 32'h0);
    check("manual keys", rd, 32'h2);
    wb(1'b0, 4'hc, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("register tests done");
    seq.put(8'h23, 1'b1, 49'h1_aaaa);
    wb(1'b1, 4'h0, 32'h1);
    seq.put(8'h23, 1'b1, 49'h2_bbbb);
    seq.put(8'h55, 1'b1, 49'h3_cccc);
    rd_store(8'h23, 49'h2_bbbb);
    wb(1'b1, 4'h0, 32'h21);
    rd_store(8'h23, 49'h1_aaaa);
    rd_store(8'h55, 49'h3_cccc);
    rd_store(8'h3a, 49'h0);
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    wb(1'b0, 4'h4, 32'h0);
    check("status after second reset", rd, 32'h0004_0000);
    $display("store and reset tests done");
    final_report();
  end
endmodule
`default_nettype wire

// file: verilog/bdms_consts.vh
// Functional notes
// - Store holds 220 words of twelve decimal digits plus sign.
// - One permanent band of sixty words plus four switchable bands of forty.
// - Exactly one switchable band is live; the permanent band always is.
// - Switchable bands numbered 0 to 3, each answering addresses 00 to 39.
// - Addresses 40 to 99 always go to the permanent band.
// - Addresses 00 to 39 go to the band named by the band switch.
// - Band switch always holds one of four valid positions, never idle.
// - Home-band command loads the band switch with operand b, 0 to 3.
// - Home-band with manual selection takes the band from the manual digit keys.
// - Step-band adds one; skip the next step when the result equals b plus one.
// - Accumulator-to-high command adds the accumulator low digit into the high pointer.
// - Accumulator-to-low command adds the accumulator low digit into the low pointer.
// - Accumulator-to-both command adds the digit into both pointers together.
// - Accumulator-to-band command adds the digit into the band switch.
// - Without expanded store, band commands are absent; pointer additions remain.
`ifndef BDMS_CONSTS_VH
`define BDMS_CONSTS_VH

`define BDMS_WORDS 220
`define BDMS_WORD_W 49
`define BDMS_HEART_BASE 7'd40
`define BDMS_BAND_BASE 8'd60
`define BDMS_BAND_SIZE 8'd40

`define BDMS_ADR_CMD 4'h0
`define BDMS_ADR_STATUS 4'h4
`define BDMS_ADR_MANUAL 4'h8

`define BDMS_OP_NOP 4'h0
`define BDMS_OP_HOME_BAND 4'h1
`define BDMS_OP_STEP_BAND 4'h2
`define BDMS_OP_ACC_HIGH 4'h3
`define BDMS_OP_ACC_LOW 4'h4
`define BDMS_OP_ACC_BOTH 4'h5
`define BDMS_OP_ACC_BAND 4'h6
`define BDMS_OP_HOME_HIGH 4'h7
`define BDMS_OP_HOME_LOW 4'h8

`define BDMS_CMD_OP_LSB 0
`define BDMS_CMD_ARG_LSB 4
`define BDMS_CMD_MANUAL_BIT 8
`define BDMS_CMD_ACC_LSB 12

`define BDMS_ST_BAND_LSB 0
`define BDMS_ST_HIGH_LSB 4
`define BDMS_ST_LOW_LSB 8
`define BDMS_ST_SKIP_BIT 16
`define BDMS_ST_ERR_BIT 17
`define BDMS_ST_EXP_BIT 18

`define BDMS_RST_BAND 2'h0
`define BDMS_RST_DIGIT 4'h0

`endif

// file: verilog/bdms_top.v
// Decided for this implementation: the register addresses and the Wishbone slave port.
`include "bdms_consts.vh"
`default_nettype none

module bdms_top #(
  parameter EXPANDED = 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] manual_digit_i,
  input wire [7:0] mem_addr_i,
  input wire mem_we_i,
  input wire [48:0] mem_wdata_i,
  output reg [48:0] mem_rdata_o,
  output reg mem_heart_o,
  output reg mem_addr_err_o,
  output reg [1:0] band_o,
  output reg [3:0] high_digit_o,
  output reg [3:0] low_digit_o,
  output reg skip_o,
  output reg err_o
);

  // Whole store as one array: permanent band first, then bands 0..3
  reg [`BDMS_WORD_W-1:0] store [0:`BDMS_WORDS-1];

  reg [3:0] man_s1;
  reg [3:0] man_s2;
  reg [3:0] man_s3;
  reg [3:0] manual;
  reg [15:0] last_cmd;

  reg [1:0] next_band;
  reg [3:0] next_high;
  reg [3:0] next_low;
  reg next_skip;
  reg cmd_bad;

  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_take = wb_req & wb_ack_o;
  wire wb_wr = wb_take & wb_we_i;
  wire cmd_wr = wb_wr & (wb_adr_i == `BDMS_ADR_CMD) & (wb_sel_i[1:0] == 2'b11);
  wire err_clr = wb_wr & (wb_adr_i == `BDMS_ADR_STATUS) & wb_sel_i[2] & wb_dat_i[`BDMS_ST_ERR_BIT];

  wire [3:0] op = wb_dat_i[`BDMS_CMD_OP_LSB+3:`BDMS_CMD_OP_LSB];
  wire [3:0] arg = wb_dat_i[`BDMS_CMD_ARG_LSB+3:`BDMS_CMD_ARG_LSB];
  wire use_manual = wb_dat_i[`BDMS_CMD_MANUAL_BIT];
  wire [3:0] acc = wb_dat_i[`BDMS_CMD_ACC_LSB+3:`BDMS_CMD_ACC_LSB];
  wire exp_on = (EXPANDED != 0);

  // Decimal addition wrapping at ten
  function [3:0] add_dec;
    input [3:0] a;
    input [3:0] b;
    reg [4:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= 5'd10) begin
        s = s - 5'd10;
      end
      add_dec = s[3:0];
    end
  endfunction

  // Band arithmetic keeps two bits, so it wraps at four
  function [1:0] add_band;
    input [1:0] a;
    input [3:0] b;
    reg [3:0] s;
    begin
      s = {2'b00, a} + b;
      add_band = s[1:0];
    end
  endfunction

  // Command execution
  always @* begin
    next_band = band_o;
    next_high = high_digit_o;
    next_low = low_digit_o;
    next_skip = skip_o;
    cmd_bad = 1'b0;
    if (cmd_wr) begin
      case (op)
        `BDMS_OP_NOP: begin
          cmd_bad = 1'b0;
        end
        `BDMS_OP_HOME_BAND: begin
          if (!exp_on) begin
            cmd_bad = 1'b1;
          end else if (use_manual) begin
            if (manual > 4'd3) begin
              cmd_bad = 1'b1;
            end else begin
              next_band = manual[1:0];
            end
          end else if (arg > 4'd3) begin
            cmd_bad = 1'b1;
          end else begin
            next_band = arg[1:0];
          end
        end
        `BDMS_OP_STEP_BAND: begin
          if (!exp_on || arg > 4'd3) begin
            cmd_bad = 1'b1;
          end else begin
            next_band = add_band(band_o, 4'd1);
            next_skip = (next_band == add_band(arg[1:0], 4'd1));
          end
        end
        `BDMS_OP_ACC_HIGH: begin
          if (acc > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_high = add_dec(high_digit_o, acc);
          end
        end
        `BDMS_OP_ACC_LOW: begin
          if (acc > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_low = add_dec(low_digit_o, acc);
          end
        end
        `BDMS_OP_ACC_BOTH: begin
          if (acc > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_high = add_dec(high_digit_o, acc);
            next_low = add_dec(low_digit_o, acc);
          end
        end
        `BDMS_OP_ACC_BAND: begin
          if (!exp_on || acc > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_band = add_band(band_o, acc);
          end
        end
        `BDMS_OP_HOME_HIGH: begin
          if (arg > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_high = arg;
          end
        end
        `BDMS_OP_HOME_LOW: begin
          if (arg > 4'd9) begin
            cmd_bad = 1'b1;
          end else begin
            next_low = arg;
          end
        end
        default: begin
          cmd_bad = 1'b1;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      band_o <= `BDMS_RST_BAND;
      high_digit_o <= `BDMS_RST_DIGIT;
      low_digit_o <= `BDMS_RST_DIGIT;
      skip_o <= 1'b0;
      err_o <= 1'b0;
      last_cmd <= 16'h0000;
    end else begin
      band_o <= next_band;
      high_digit_o <= next_high;
      low_digit_o <= next_low;
      skip_o <= next_skip;
      // A fresh error outweighs a clear in the same cycle
      err_o <= cmd_bad | (err_o & ~err_clr);
      if (cmd_wr) begin
        last_cmd <= wb_dat_i[15:0];
      end
    end
  end

  // Manual keys: three stages, accept a value once the last two agree
  always @(posedge clk_i) begin
    if (reset_i) begin
      man_s1 <= 4'h0;
      man_s2 <= 4'h0;
      man_s3 <= 4'h0;
      manual <= 4'h0;
    end else begin
      man_s1 <= manual_digit_i;
      man_s2 <= man_s1;
      man_s3 <= man_s2;
      if (man_s2 == man_s3) begin
        manual <= man_s3;
      end
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  always @(posedge clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_req & ~wb_ack_o & ~wb_we_i) begin
        case (wb_adr_i)
          `BDMS_ADR_CMD: begin
            wb_dat_o <= {16'h0000, last_cmd};
          end
          `BDMS_ADR_STATUS: begin
            wb_dat_o[`BDMS_ST_BAND_LSB+1:`BDMS_ST_BAND_LSB] <= band_o;
            wb_dat_o[`BDMS_ST_HIGH_LSB+3:`BDMS_ST_HIGH_LSB] <= high_digit_o;
            wb_dat_o[`BDMS_ST_LOW_LSB+3:`BDMS_ST_LOW_LSB] <= low_digit_o;
            wb_dat_o[`BDMS_ST_SKIP_BIT] <= skip_o;
            wb_dat_o[`BDMS_ST_ERR_BIT] <= err_o;
            wb_dat_o[`BDMS_ST_EXP_BIT] <= exp_on;
          end
          `BDMS_ADR_MANUAL: begin
            wb_dat_o[3:0] <= manual;
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Address decode: two decimal digits to a store index
  wire [3:0] tens = mem_addr_i[7:4];
  wire [3:0] ones = mem_addr_i[3:0];
  wire addr_ok = (tens <= 4'd9) && (ones <= 4'd9);
  wire [6:0] addr_val = {3'b000, tens} * 7'd10 + {3'b000, ones};
  wire is_heart = (addr_val >= `BDMS_HEART_BASE);
  wire [1:0] live_band = exp_on ? band_o : 2'b00;
  wire [7:0] heart_idx = {1'b0, addr_val - `BDMS_HEART_BASE};
  wire [7:0] band_idx = `BDMS_BAND_BASE + {6'b000000, live_band} * `BDMS_BAND_SIZE + {1'b0, addr_val};
  wire [7:0] store_idx = is_heart ? heart_idx : band_idx;

  always @(posedge clk_i) begin
    if (reset_i) begin
      mem_rdata_o <= {`BDMS_WORD_W{1'b0}};
      mem_heart_o <= 1'b0;
      mem_addr_err_o <= 1'b0;
    end else begin
      mem_heart_o <= addr_ok & is_heart;
      mem_addr_err_o <= ~addr_ok;
      if (addr_ok) begin
        mem_rdata_o <= store[store_idx];
      end else begin
        mem_rdata_o <= {`BDMS_WORD_W{1'b0}};
      end
    end
  end

  always @(posedge clk_i) begin
    if (addr_ok & mem_we_i) begin
      store[store_idx] <= mem_wdata_i;
    end
  end

endmodule

`default_nettype wire
